/* File: hw/pmfs_regs.svh */
// Register offsets, field positions, reset values and codes of the power mode and fault block
`ifndef PMFS_REGS_SVH
`define PMFS_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (register port address)
// ----------------------------------------------------------------
`define PMFS_ADDR_W 12
`define PMFS_OFS_INIT_COMPLETE 12'h0270
`define PMFS_OFS_PROFILE_B 12'h029a
`define PMFS_OFS_PROFILE_C 12'h029b
`define PMFS_OFS_PROFILE_D 12'h029c
`define PMFS_OFS_FAULT_SUMMARY 12'h02c0
`define PMFS_OFS_FAULT_FLAGS 12'h02c1
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMFS_RST_PROFILE_B 8'h0f
`define PMFS_RST_PROFILE_C 8'h04
`define PMFS_RST_PROFILE_D 8'h1b
`define PMFS_RST_FAULT_FLAGS 8'h3f
`define PMFS_RST_FAULT_MASK 8'h3f
// ----------------------------------------------------------------
// Profile codes
// ----------------------------------------------------------------
`define PMFS_B_LOW 8'h06
`define PMFS_B_HIGH 8'h0f
`define PMFS_C_LOW 8'h00
`define PMFS_C_HIGH 8'h04
`define PMFS_D_LOW 8'h14
`define PMFS_D_HIGH 8'h1b
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMFS_BIT_INIT_DONE 0
`define PMFS_BIT_SUMMARY 0
`define PMFS_BIT_FIFO 5
`define PMFS_BIT_SPLL 4
`define PMFS_BIT_LINK 3
`define PMFS_BIT_REALIGN 2
`define PMFS_BIT_CLKDIV 0
`define PMFS_FLAGS_IMPL 8'h3f
`endif

/* File: hw/pmfs_pkg.sv */
// Types shared by the power mode and fault summary block
package pmfs_pkg;
  // Decoded operating mode of one profile field
  typedef enum logic [1:0] {
    PMFS_MODE_HIGH = 2'b00,
    PMFS_MODE_LOW = 2'b01,
    PMFS_MODE_RSVD = 2'b10
  } pmfs_mode_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } pmfs_req_t;
  // Fault events, one pulse each
  typedef struct packed {
    logic lane_fifo_fault;
    logic serializer_pll_fault;
    logic link_state_fault;
    logic sysref_realign_fault;
    logic reserved_fault;
    logic clock_divider_fault;
  } pmfs_events_t;
endpackage

/* File: hw/pmfs_fault_flags.sv */
// Sticky write-one-to-clear fault flags
`timescale 1ns/1ps
`include "pmfs_regs.svh"
module pmfs_fault_flags
  import pmfs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] set_bits,
  input wire logic [7:0] clr_bits,
  output logic [7:0] flags
);
  logic [7:0] next_flags;
  // Set wins over clear; bits 7:6 stay zero
  always_comb begin
    next_flags = ((flags & ~clr_bits) | set_bits) & `PMFS_FLAGS_IMPL;
  end
  // All flags come up set after reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags <= `PMFS_RST_FAULT_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end
  property p_set_wins;
    @(posedge mclk) disable iff (!nrst)
      (set_bits[`PMFS_BIT_FIFO] && clr_bits[`PMFS_BIT_FIFO]) |=> flags[`PMFS_BIT_FIFO];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("fault set lost to clear");
  property p_clear;
    @(posedge mclk) disable iff (!nrst)
      (clr_bits[`PMFS_BIT_SPLL] && !set_bits[`PMFS_BIT_SPLL]) |=> !flags[`PMFS_BIT_SPLL];
  endproperty
  a_clear: assert property (p_clear) else $error("fault flag not cleared");
endmodule // pmfs_fault_flags

/* File: hw/pmfs_top.sv */
// Power profile, init status and fault summary register bank
// Notes on behaviour
// - Init status bit 0 reads 1 once internal initialization has finished, else 0.
// - Profile b selects low power at 0x06 and high performance at 0x0F (reset).
// - Profile c selects low power at 0x00 and high performance at 0x04 (reset).
// - Profile d selects low power at 0x14 and high performance at 0x1B (reset).
// - Fault summary bit 0 is 1 whenever any unmasked fault flag is set.
// - A set fault mask bit keeps its flag out of the summary.
// - When selected, the summary drives the calibration status pin as an interrupt.
// - Fault flags sit at bits 5,4,3,2,1,0, are set by events and cleared by writing 1.
// - After power-on or software reset every fault flag reads 1.
`timescale 1ns/1ps
`include "pmfs_regs.svh"
module pmfs_top
  import pmfs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic soft_reset,
  input wire logic init_finished,
  input wire pmfs_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire pmfs_events_t events,
  input wire logic [7:0] fault_mask,
  input wire logic cal_status_sel,
  input wire logic cal_done,
  input wire logic serial_link_enable,
  input wire logic cal_enable,
  output logic calibration_status_pin,
  output pmfs_mode_t power_mode,
  output logic low_power_en
);
  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic pmfs_mode_t decode_mode(input logic [7:0] code, input logic [7:0] lo,
                                             input logic [7:0] hi);
    if (code == lo) begin
      decode_mode = PMFS_MODE_LOW;
    end else if (code == hi) begin
      decode_mode = PMFS_MODE_HIGH;
    end else begin
      decode_mode = PMFS_MODE_RSVD;
    end
  endfunction
  function automatic logic is_write(input pmfs_req_t r, input logic [11:0] ofs);
    is_write = r.wr && (r.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] profile_b;
  logic [7:0] profile_c;
  logic [7:0] profile_d;
  logic init_done;
  logic fault_summary;
  logic [7:0] flags;
  logic [7:0] next_profile_b;
  logic [7:0] next_profile_c;
  logic [7:0] next_profile_d;
  logic next_init_done;
  logic next_fault_summary;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_cal_pin;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  pmfs_mode_t mode_b;
  pmfs_mode_t mode_c;
  pmfs_mode_t mode_d;
  pmfs_mode_t next_power_mode;
  logic local_rst;

  assign local_rst = soft_reset;

  // Event pulses into flag positions, write-one clears
  always_comb begin
    set_bits = 8'h00;
    set_bits[`PMFS_BIT_FIFO] = events.lane_fifo_fault;
    set_bits[`PMFS_BIT_SPLL] = events.serializer_pll_fault;
    set_bits[`PMFS_BIT_LINK] = events.link_state_fault;
    set_bits[`PMFS_BIT_REALIGN] = events.sysref_realign_fault;
    set_bits[1] = events.reserved_fault;
    set_bits[`PMFS_BIT_CLKDIV] = events.clock_divider_fault;
    if (local_rst) begin
      set_bits = `PMFS_RST_FAULT_FLAGS;
    end
    clr_bits = is_write(req, `PMFS_OFS_FAULT_FLAGS) ? req.wdata : 8'h00;
  end

  pmfs_fault_flags u_flags (
    .mclk(mclk),
    .nrst(nrst),
    .set_bits(set_bits),
    .clr_bits(clr_bits),
    .flags(flags)
  );

  // Next state of profiles, summary, status and read data
  always_comb begin
    next_profile_b = profile_b;
    next_profile_c = profile_c;
    next_profile_d = profile_d;
    if (is_write(req, `PMFS_OFS_PROFILE_B)) begin
      next_profile_b = req.wdata;
    end
    if (is_write(req, `PMFS_OFS_PROFILE_C)) begin
      next_profile_c = req.wdata;
    end
    if (is_write(req, `PMFS_OFS_PROFILE_D)) begin
      next_profile_d = req.wdata;
    end
    if (local_rst) begin
      next_profile_b = `PMFS_RST_PROFILE_B;
      next_profile_c = `PMFS_RST_PROFILE_C;
      next_profile_d = `PMFS_RST_PROFILE_D;
    end
    next_init_done = init_finished && !local_rst;
    next_fault_summary = |(flags & ~fault_mask & `PMFS_FLAGS_IMPL);
    next_cal_pin = cal_status_sel ? next_fault_summary : cal_done;
    mode_b = decode_mode(profile_b, `PMFS_B_LOW, `PMFS_B_HIGH);
    mode_c = decode_mode(profile_c, `PMFS_C_LOW, `PMFS_C_HIGH);
    mode_d = decode_mode(profile_d, `PMFS_D_LOW, `PMFS_D_HIGH);
    if (mode_b == mode_c && mode_c == mode_d) begin
      next_power_mode = mode_b;
    end else begin
      next_power_mode = PMFS_MODE_RSVD;
    end
    next_rvalid = req.rd;
    next_rdata = 8'h00;
    if (req.addr == `PMFS_OFS_INIT_COMPLETE) begin
      next_rdata[`PMFS_BIT_INIT_DONE] = init_done;
    end else if (req.addr == `PMFS_OFS_PROFILE_B) begin
      next_rdata = profile_b;
    end else if (req.addr == `PMFS_OFS_PROFILE_C) begin
      next_rdata = profile_c;
    end else if (req.addr == `PMFS_OFS_PROFILE_D) begin
      next_rdata = profile_d;
    end else if (req.addr == `PMFS_OFS_FAULT_SUMMARY) begin
      next_rdata[`PMFS_BIT_SUMMARY] = fault_summary;
    end else if (req.addr == `PMFS_OFS_FAULT_FLAGS) begin
      next_rdata = flags;
    end
    if (!req.rd) begin
      next_rdata = rdata;
    end
  end

  // Register everything
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      profile_b <= `PMFS_RST_PROFILE_B;
      profile_c <= `PMFS_RST_PROFILE_C;
      profile_d <= `PMFS_RST_PROFILE_D;
      init_done <= 1'b0;
      fault_summary <= 1'b0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      calibration_status_pin <= 1'b0;
      power_mode <= PMFS_MODE_HIGH;
    end else begin
      profile_b <= next_profile_b;
      profile_c <= next_profile_c;
      profile_d <= next_profile_d;
      init_done <= next_init_done;
      fault_summary <= next_fault_summary;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      calibration_status_pin <= next_cal_pin;
      power_mode <= next_power_mode;
    end
  end

  assign low_power_en = (power_mode == PMFS_MODE_LOW);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_init_done;
    @(posedge mclk) disable iff (!nrst) (init_finished && !soft_reset) |=> init_done;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init done missing");
  property p_init_low;
    @(posedge mclk) disable iff (!nrst) !init_finished |=> !init_done;
  endproperty
  a_init_low: assert property (p_init_low) else $error("init done early");
  property p_b_low;
    @(posedge mclk) disable iff (!nrst) (profile_b == `PMFS_B_LOW) |-> (mode_b == PMFS_MODE_LOW);
  endproperty
  a_b_low: assert property (p_b_low) else $error("profile b decode");
  property p_c_high;
    @(posedge mclk) disable iff (!nrst)
      (profile_c == `PMFS_C_HIGH) |-> (mode_c == PMFS_MODE_HIGH);
  endproperty
  a_c_high: assert property (p_c_high) else $error("profile c decode");
  property p_d_low;
    @(posedge mclk) disable iff (!nrst) (profile_d == `PMFS_D_LOW) |-> (mode_d == PMFS_MODE_LOW);
  endproperty
  a_d_low: assert property (p_d_low) else $error("profile d decode");
  sequence s_unmasked_flag;
    |(flags & ~fault_mask & `PMFS_FLAGS_IMPL);
  endsequence
  property p_summary;
    @(posedge mclk) disable iff (!nrst) s_unmasked_flag |=> fault_summary;
  endproperty
  a_summary: assert property (p_summary) else $error("summary not raised");
  property p_masked;
    @(posedge mclk) disable iff (!nrst)
      ((flags & ~fault_mask & `PMFS_FLAGS_IMPL) == 8'h00) |=> !fault_summary;
  endproperty
  a_masked: assert property (p_masked) else $error("masked flag leaked");
  property p_pin;
    @(posedge mclk) disable iff (!nrst)
      cal_status_sel |=> (calibration_status_pin == $past(next_fault_summary));
  endproperty
  a_pin: assert property (p_pin) else $error("status pin not summary");
  property p_soft;
    @(posedge mclk) disable iff (!nrst) soft_reset |=> (flags == `PMFS_RST_FAULT_FLAGS);
  endproperty
  a_soft: assert property (p_soft) else $error("flags not set by soft reset");
endmodule // pmfs_top

/* File: verification/pmfs_host.sv */
// Host model on the register port of the power mode and fault block
`timescale 1ns/1ps
`include "pmfs_regs.svh"
module pmfs_host
  import pmfs_pkg::*;
#(
  parameter int SAMPLE_MSPS = 1000
)
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output pmfs_req_t req,
  output logic serial_link_enable,
  output logic cal_enable
);
  // Idle port, link and calibration running
  initial begin
    req = '0;
    serial_link_enable = 1'b1;
    cal_enable = 1'b1;
  end
  // One write, strobe held for the single taking edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '0;
  endtask
  // One read, data taken at the edge that shows rvalid
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
  // Poll init status before any other traffic
  task automatic wait_init();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 20 && d[0] !== 1'b1; i++) begin
      rd(`PMFS_OFS_INIT_COMPLETE, d);
    end
  endtask
  // All profiles in one go, then recalibrate, but nothing when low is asked above 1000 MSPS; split breaks the pairing on purpose
  task automatic set_mode(input bit low, input bit split);
    if (low && SAMPLE_MSPS > 1000) begin
      return;
    end
    serial_link_enable <= 1'b0;
    cal_enable <= 1'b0;
    wr(`PMFS_OFS_PROFILE_B, low ? `PMFS_B_LOW : `PMFS_B_HIGH);
    wr(`PMFS_OFS_PROFILE_C, (low ^ split) ? `PMFS_C_LOW : `PMFS_C_HIGH);
    wr(`PMFS_OFS_PROFILE_D, (low ^ split) ? `PMFS_D_LOW : `PMFS_D_HIGH);
    cal_enable <= 1'b1;
    serial_link_enable <= 1'b1;
  endtask
endmodule // pmfs_host

/* File: verification/pmfs_top_tb.sv */
// Self-checking bench for the power mode and fault summary registers
`timescale 1ns/1ps
module pmfs_top_tb
  import pmfs_pkg::*;
;
  logic mclk, nrst, soft_reset, init_finished, cal_status_sel, cal_done, rvalid, pin, lpe;
  logic sle, cen;
  logic [7:0] rdata, fault_mask, rd_v, wd, mk, exp_v;
  logic [5:0] ev;
  pmfs_req_t req;
  pmfs_events_t events;
  pmfs_mode_t power_mode;
  int error_cnt = 0, checks = 0, cycles = 0, seed, m_flags;
  logic [11:0] ofs[6] = '{12'h0270, 12'h029a, 12'h029b, 12'h029c, 12'h02c0, 12'h02c1};
  logic [7:0] rst_v[6] = '{8'h01, 8'h0f, 8'h04, 8'h1b, 8'h00, 8'h3f};
  logic [7:0] lo_c[3] = '{8'h06, 8'h00, 8'h14};
  logic [7:0] hi_c[3] = '{8'h0f, 8'h04, 8'h1b};
  pmfs_top dut_u(.mclk(mclk), .nrst(nrst), .soft_reset(soft_reset),
    .init_finished(init_finished), .req(req), .rdata(rdata), .rvalid(rvalid),
    .events(events), .fault_mask(fault_mask), .cal_status_sel(cal_status_sel),
    .cal_done(cal_done), .serial_link_enable(sle), .cal_enable(cen),
    .calibration_status_pin(pin), .power_mode(power_mode), .low_power_en(lpe));
  pmfs_host host_u(.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req),
    .serial_link_enable(sle), .cal_enable(cen));
  // Compare one value and count it
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Clock of 100 ns
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Cycle ceiling against a hung run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    seed = 32'h8a9b;
    {nrst, soft_reset, init_finished, cal_status_sel, cal_done} = 5'h00;
    events = '0;
    fault_mask = 8'h3f;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    host_u.rd(ofs[0], rd_v);
    check("init_before", rd_v, 8'h00);
    init_finished <= 1'b1;
    host_u.wait_init();
    for (int i = 0; i < 6; i++) begin
      host_u.rd(ofs[i], rd_v);
      check("reset_value", rd_v, rst_v[i]);
    end
    host_u.wr(ofs[4], 8'hff);
    host_u.rd(ofs[4], rd_v);
    check("summary_ro", rd_v, 8'h00);
    host_u.rd(12'h0300 + 12'($random(seed) & 'hff), rd_v);
    check("unmapped", rd_v, 8'h00);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      host_u.set_mode(m != 1, m == 2);
      repeat (2) @(posedge mclk);
      for (int j = 0; j < 3; j++) begin
        host_u.rd(ofs[j + 1], rd_v);
        exp_v = (m == 0 || (m == 2 && j == 0)) ? lo_c[j] : hi_c[j];
        check("profile", rd_v, exp_v);
      end
      check("mode", {6'h00, power_mode}, (m == 0) ? 8'h01 : (m == 1) ? 8'h00 : 8'h02);
      check("low_power_en", {7'h00, lpe}, {7'h00, m == 0});
    end
    $display("test modes done");
    m_flags = 'h3f;
    for (int k = 0; k < 40; k++) begin
      ev = 6'($random(seed));
      wd = 8'($random(seed));
      mk = 8'($random(seed));
      @(posedge mclk);
      fault_mask <= mk;
      cal_status_sel <= k[1];
      cal_done <= k[2];
      events <= (k % 2) ? ev : 6'h00;
      m_flags = (m_flags | ((k % 2) ? ev : 0)) & ~wd & 'h3f;
      // Some odd passes hold the event into the clear cycle, where the set must win
      if (k[2] && (k % 2)) begin
        m_flags = m_flags | ev;
      end
      @(posedge mclk);
      if (!k[2]) begin
        events <= '0;
      end
      host_u.wr(ofs[5], wd);
      events <= '0;
      host_u.rd(ofs[5], rd_v);
      check("fault_flags", rd_v, 8'(m_flags));
      host_u.rd(ofs[4], rd_v);
      check("summary", rd_v, {7'h00, (m_flags & ~mk & 'h3f) != 0});
      check("pin", {7'h00, pin}, {7'h00, k[1] ? (m_flags & ~mk & 'h3f) != 0 : k[2]});
    end
    fault_mask <= 8'h00;
    cal_status_sel <= 1'b1;
    events <= 6'h3f;
    @(posedge mclk);
    events <= '0;
    repeat (4) @(posedge mclk);
    host_u.wr(ofs[5], 8'h3f);
    // Pin is registered beside the summary, so both drop one cycle after the clear
    @(posedge mclk);
    check("pin_hold", {7'h00, pin}, 8'h01);
    @(posedge mclk);
    check("pin_fall", {7'h00, pin}, 8'h00);
    $display("test faults done");
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    host_u.wait_init();
    for (int i = 1; i < 6; i++) begin
      host_u.rd(ofs[i], rd_v);
      check("soft_reset", rd_v, (i == 4) ? 8'h01 : rst_v[i]);
    end
    check("soft_mode", {6'h00, power_mode}, 8'h00);
    $display("test soft reset done");
    conclude();
  end
endmodule // pmfs_top_tb
